// ### lcdd_top.sv
// Four-digit seven-segment static LCD decoder/driver with bus latches
//
// How it works
// - Twenty-eight segment outputs plus one common-plane driver.
// - Segments grouped per digit; digit one least, digit four most significant.
// - Internal oscillator near 16 kHz, divided by 128 to 125 Hz plane.
// - Grounded timebase pin disables plane driver; segments follow external plane.
// - A timebase pin seen as high is never taken as grounded.
// - Low pulses shorter than 1 us on timebase pin are ignored.
// - Data is 4-bit active-high; bit 0 least significant.
// - Data and digit code captured together in input buffer latches.
// - Rising edge of either chip select stores decoded value in chosen digit.
// - Digit code picks one latch; the other three keep their contents.
// - Values 0-9 show digits; 10-15 show dash, E, H, L, P, blank.
// - Code 00 digit four, 01 three, 10 two, 11 one.
// - Buffer latches transparent only while both chip selects are low.
`timescale 1ns/100ps
module lcdd_top (
   input wire logic clock,
   input wire logic reset,
   input wire logic data_in_bit0,
   input wire logic data_in_bit1,
   input wire logic data_in_bit2,
   input wire logic data_in_bit3,
   input wire logic digit_pick_low,
   input wire logic digit_pick_high,
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second_n,
   input wire logic timebase_pin,
   input wire logic common_plane_in,
   output logic common_plane_out,
   output logic common_plane_oe,
   output logic [6:0] digit_one,
   output logic [6:0] digit_two,
   output logic [6:0] digit_three,
   output logic [6:0] digit_four
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] cs1_sync_ff, cs2_sync_ff, tb_sync_ff, cp_sync_ff;
   logic [5:0] word_meta_ff, word_sync_ff;

   // Two flops on every pin; only the second stage is read
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cs1_sync_ff <= 2'h3;
         cs2_sync_ff <= 2'h3;
         tb_sync_ff <= 2'h3;
         cp_sync_ff <= 2'h0;
         word_meta_ff <= 6'h00;
         word_sync_ff <= 6'h00;
      end else begin
         cs1_sync_ff <= {cs1_sync_ff[0], chip_sel_first_n};
         cs2_sync_ff <= {cs2_sync_ff[0], chip_sel_second_n};
         tb_sync_ff <= {tb_sync_ff[0], timebase_pin};
         cp_sync_ff <= {cp_sync_ff[0], common_plane_in};
         word_meta_ff <= {digit_pick_high, digit_pick_low, data_in_bit3, data_in_bit2,
                          data_in_bit1, data_in_bit0};
         word_sync_ff <= word_meta_ff;
      end
   end

   wire logic cs1_s = cs1_sync_ff[1];
   wire logic cs2_s = cs2_sync_ff[1];
   wire logic tb_s = tb_sync_ff[1];
   wire logic cp_s = cp_sync_ff[1];

   // ****************************************
   // Input buffer latch and strobe
   // ****************************************
   lcdd_pkg::lcdd_word_t buf_ff;
   logic cs1_prev_ff, cs2_prev_ff;
   logic open_now, store_pulse;

   assign open_now = !cs1_s && !cs2_s;
   // A rise on either select ends the write; the latch is already closed then
   assign store_pulse = (cs1_s && !cs1_prev_ff) || (cs2_s && !cs2_prev_ff);

   // Buffer follows the bus only while both selects are low
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         buf_ff <= '0;
      end else if (open_now) begin
         buf_ff <= lcdd_pkg::lcdd_word_t'(word_sync_ff);
      end
   end

   // Previous select levels for edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cs1_prev_ff <= 1'b1;
         cs2_prev_ff <= 1'b1;
      end else begin
         cs1_prev_ff <= cs1_s;
         cs2_prev_ff <= cs2_s;
      end
   end

   // ****************************************
   // Digit latches
   // ****************************************
   lcdd_pkg::lcdd_seg_t digit_ff [lcdd_pkg::DIGITS];

   // Only the addressed latch loads; others hold until rewritten
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < lcdd_pkg::DIGITS; i++) begin
            digit_ff[i] <= lcdd_pkg::SEG_RESET;
         end
      end else if (store_pulse) begin
         digit_ff[lcdd_pkg::lcdd_slot(buf_ff.digit_pick)] <=
            lcdd_pkg::lcdd_font(buf_ff.value);
      end
   end

   // ****************************************
   // Timebase and divide-by-128
   // ****************************************
   logic [lcdd_pkg::OSC_CNT_W-1:0] osc_cnt_ff;
   logic osc_ff, tb_prev_ff;
   logic [lcdd_pkg::DIV_W-1:0] div_ff;
   logic osc_rise;

   // Internal oscillator toggles every half period
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         osc_cnt_ff <= '0;
         osc_ff <= 1'b0;
      end else if (osc_cnt_ff == lcdd_pkg::OSC_HALF_LAST) begin
         osc_cnt_ff <= '0;
         osc_ff <= !osc_ff;
      end else begin
         osc_cnt_ff <= osc_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tb_prev_ff <= 1'b1;
      end else begin
         tb_prev_ff <= tb_s;
      end
   end

   // An external clock on the timebase pin steps the divider alongside the internal one
   assign osc_rise = (osc_cnt_ff == lcdd_pkg::OSC_HALF_LAST && !osc_ff)
                     || (tb_s && !tb_prev_ff);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_ff <= '0;
      end else if (osc_rise) begin
         div_ff <= div_ff + 1'b1;
      end
   end

   // ****************************************
   // Grounded-pin detector
   // ****************************************
   logic [lcdd_pkg::LOW_CNT_W-1:0] low_cnt_ff;
   lcdd_pkg::lcdd_mode_t mode_ff;

   // Slave mode only after a low held 1 us; short lows of a driven clock pass
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         low_cnt_ff <= '0;
         mode_ff <= lcdd_pkg::LCDD_MASTER;
      end else if (tb_s) begin
         low_cnt_ff <= '0;
         mode_ff <= lcdd_pkg::LCDD_MASTER;
      end else if (low_cnt_ff == lcdd_pkg::LOW_CNT_MAX) begin
         mode_ff <= lcdd_pkg::LCDD_SLAVE;
      end else begin
         low_cnt_ff <= low_cnt_ff + 1'b1;
      end
   end

   // ****************************************
   // Output drivers
   // ****************************************
   logic plane_ref;
   assign plane_ref = (mode_ff == lcdd_pkg::LCDD_SLAVE) ? cp_s : div_ff[lcdd_pkg::DIV_W-1];

   // Registered drives; lit segments invert the plane, so no DC across the glass
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         common_plane_out <= 1'b0;
         common_plane_oe <= 1'b1;
         digit_one <= lcdd_pkg::SEG_RESET;
         digit_two <= lcdd_pkg::SEG_RESET;
         digit_three <= lcdd_pkg::SEG_RESET;
         digit_four <= lcdd_pkg::SEG_RESET;
      end else begin
         common_plane_out <= div_ff[lcdd_pkg::DIV_W-1];
         common_plane_oe <= (mode_ff == lcdd_pkg::LCDD_MASTER);
         digit_one <= digit_ff[0] ^ {lcdd_pkg::SEGS{plane_ref}};
         digit_two <= digit_ff[1] ^ {lcdd_pkg::SEGS{plane_ref}};
         digit_three <= digit_ff[2] ^ {lcdd_pkg::SEGS{plane_ref}};
         digit_four <= digit_ff[3] ^ {lcdd_pkg::SEGS{plane_ref}};
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_slave_disables: assert property (@(posedge clock) disable iff (reset)
      mode_ff == lcdd_pkg::LCDD_SLAVE |=> !common_plane_oe)
      else $error("plane driver on in slave mode");
   chk_high_master: assert property (@(posedge clock) disable iff (reset)
      tb_s |=> mode_ff == lcdd_pkg::LCDD_MASTER)
      else $error("high timebase taken as ground");
   chk_short_low: assert property (@(posedge clock) disable iff (reset)
      tb_s ##1 !tb_s |-> mode_ff == lcdd_pkg::LCDD_MASTER [*8])
      else $error("short low caused slave mode");
   chk_store_one: assert property (@(posedge clock) disable iff (reset)
      store_pulse && buf_ff.digit_pick == lcdd_pkg::SEL_DIGIT_ONE
      |=> digit_ff[0] == lcdd_pkg::lcdd_font($past(buf_ff.value)))
      else $error("digit one not stored");
   chk_store_four: assert property (@(posedge clock) disable iff (reset)
      store_pulse && buf_ff.digit_pick == lcdd_pkg::SEL_DIGIT_FOUR
      |=> digit_ff[3] == lcdd_pkg::lcdd_font($past(buf_ff.value))
          && $stable(digit_ff[0]))
      else $error("digit four store wrong");
   chk_hold_idle: assert property (@(posedge clock) disable iff (reset)
      !store_pulse |=> $stable(digit_ff[1]) && $stable(digit_ff[2]))
      else $error("digit latch changed without strobe");
   chk_buffer_closed: assert property (@(posedge clock) disable iff (reset)
      !open_now |=> $stable(buf_ff))
      else $error("buffer moved while closed");
   chk_antiphase: assert property (@(posedge clock) disable iff (reset)
      $stable(plane_ref) && $stable(digit_ff[0])
      |=> digit_one == ($past(digit_ff[0]) ^ {lcdd_pkg::SEGS{$past(plane_ref)}}))
      else $error("segment phase wrong");
   chk_divider: assert property (@(posedge clock) disable iff (reset)
      osc_rise |=> div_ff == $past(div_ff) + 1'b1)
      else $error("divider missed a step");

endmodule

// ### lcdd_pkg.sv
// Package for the four-digit LCD decoder/driver: constants, types and font
package lcdd_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int OSC_FREQ_HZ = 16000;
   // Oscillator period in ps, rounded down
   localparam int OSC_PERIOD_PS = 1000000000 / OSC_FREQ_HZ * 1000;
   // Half an oscillator period in clock cycles
   localparam int OSC_HALF_CYC = OSC_PERIOD_PS / 2 / CLK_PERIOD_PS;
   localparam int OSC_CNT_W = 14;
   localparam logic [OSC_CNT_W-1:0] OSC_HALF_LAST = OSC_CNT_W'(OSC_HALF_CYC - 1);
   localparam int PLANE_DIV = 128;
   localparam int DIV_W = 7;
   localparam int LOW_GLITCH_NS = 1000;
   // Least low time before grounding is believed, rounded up
   localparam int LOW_GLITCH_CYC = (LOW_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOW_CNT_W = 9;
   localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = LOW_CNT_W'(LOW_GLITCH_CYC);

   // ****************************************
   // Widths and codes
   // ****************************************
   localparam int DIGITS = 4;
   localparam int SEGS = 7;
   localparam logic [1:0] SEL_DIGIT_FOUR = 2'h0;
   localparam logic [1:0] SEL_DIGIT_THREE = 2'h1;
   localparam logic [1:0] SEL_DIGIT_TWO = 2'h2;
   localparam logic [1:0] SEL_DIGIT_ONE = 2'h3;
   localparam logic [6:0] SEG_RESET = 7'h00;

   // Bus word captured by the input buffer latches
   typedef struct packed {
      logic [1:0] digit_pick;
      logic [3:0] value;
   } lcdd_word_t;

   // Segment pattern, bit 0 = a ... bit 6 = g
   typedef logic [6:0] lcdd_seg_t;

   typedef enum logic [0:0] {
      LCDD_MASTER = 1'b0,
      LCDD_SLAVE = 1'b1
   } lcdd_mode_t;

   // Code B font: 0-9, dash, E, H, L, P, blank
   function automatic lcdd_seg_t lcdd_font(input logic [3:0] v);
      case (v)
         4'h0: lcdd_font = 7'h3f;
         4'h1: lcdd_font = 7'h06;
         4'h2: lcdd_font = 7'h5b;
         4'h3: lcdd_font = 7'h4f;
         4'h4: lcdd_font = 7'h66;
         4'h5: lcdd_font = 7'h6d;
         4'h6: lcdd_font = 7'h7d;
         4'h7: lcdd_font = 7'h07;
         4'h8: lcdd_font = 7'h7f;
         4'h9: lcdd_font = 7'h6f;
         4'ha: lcdd_font = 7'h40;
         4'hb: lcdd_font = 7'h79;
         4'hc: lcdd_font = 7'h76;
         4'hd: lcdd_font = 7'h38;
         4'he: lcdd_font = 7'h73;
         default: lcdd_font = 7'h00;
      endcase
   endfunction

   // Digit code to latch index (0 = digit one, least significant)
   function automatic logic [1:0] lcdd_slot(input logic [1:0] code);
      lcdd_slot = ~code;
   endfunction

endpackage

// ### lcdd_plane_src.sv
// Far-side model: external common-plane source and common-plane pin resolution
`timescale 1ns/100ps
module lcdd_plane_src #(
   parameter int HALF = 64
) (
   input wire logic clock,
   input wire logic run,
   input wire logic plane_oe,
   input wire logic plane_out,
   output logic plane_pin
);
   // ****************************************
   // External plane generator
   // ****************************************
   logic ext_ff;
   int cnt_ff;
   initial begin
      ext_ff = 1'b0;
      cnt_ff = 0;
   end
   // Square wave only while running, so the plane stands still when idle
   always @(posedge clock) begin
      if (run && cnt_ff == HALF - 1) begin
         ext_ff <= ~ext_ff;
         cnt_ff <= 0;
      end else if (run) begin
         cnt_ff <= cnt_ff + 1;
      end
   end
   // Device drive wins while enabled; otherwise the external source owns the pin
   assign plane_pin = plane_oe ? plane_out : ext_ff;
endmodule

// ### bus_lcd_four_digit_decoder_tb_top.sv
// Self-checking testbench for the four-digit LCD decoder and driver
`timescale 1ns/100ps
module bus_lcd_four_digit_decoder_tb_top;
   // ****************************************
   // Signals and expected font
   // ****************************************
   localparam logic [6:0] FONT [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
      7'h07, 7'h7f, 7'h6f, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
   logic clock;
   logic reset;
   logic [3:0] data;
   logic [1:0] pick;
   logic cs1_n;
   logic cs2_n;
   logic timebase;
   logic run;
   logic plane_pin;
   logic plane_out;
   logic plane_oe;
   logic [6:0] dig [4];
   logic [6:0] exp_pat [4];
   int failures;
   int compares;

   lcdd_top DUT (.clock(clock), .reset(reset), .data_in_bit0(data[0]),
      .data_in_bit1(data[1]), .data_in_bit2(data[2]), .data_in_bit3(data[3]),
      .digit_pick_low(pick[0]), .digit_pick_high(pick[1]), .chip_sel_first_n(cs1_n),
      .chip_sel_second_n(cs2_n), .timebase_pin(timebase), .common_plane_in(plane_pin),
      .common_plane_out(plane_out), .common_plane_oe(plane_oe), .digit_one(dig[0]),
      .digit_two(dig[1]), .digit_three(dig[2]), .digit_four(dig[3]));

   lcdd_plane_src #(.HALF(64)) plane_src (.clock(clock), .run(run), .plane_oe(plane_oe),
      .plane_out(plane_out), .plane_pin(plane_pin));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic check_seg(input logic [6:0] got, input logic [6:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t segments got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t plane flag got %b expected %b", $time, got, exp);
      end
   endtask

   // Lit segments sit opposite the plane level, unlit ones follow it
   task automatic check_all(input logic lvl);
      for (int i = 0; i < 4; i++) begin
         check_seg(dig[i], exp_pat[i] ^ {7{lvl}});
      end
   endtask

   // One write: the chosen select rises first and is checked before the other rises, so each select is proven alone
   task automatic bus_write(input logic [3:0] v, input logic [1:0] code, input logic second);
      data = v;
      pick = code;
      cs1_n = 1'b0;
      cs2_n = 1'b0;
      idle(5);
      if (second) begin
         cs2_n = 1'b1;
      end else begin
         cs1_n = 1'b1;
      end
      idle(8);
      exp_pat[~code] = FONT[v];
      check_all(plane_out);
      cs1_n = 1'b1;
      cs2_n = 1'b1;
      idle(6);
   endtask

   // Bounded wait for the next plane edge from the far side
   task automatic wait_pin;
      logic old;
      old = plane_pin;
      for (int i = 0; i < 300 && plane_pin === old; i++) begin
         @(negedge clock);
      end
   endtask

   // One short low on the timebase pin, well under the grounding limit
   task automatic pulse_tb;
      timebase = 1'b0;
      idle(2);
      timebase = 1'b1;
      idle(4);
   endtask

   // External rises step the divider; the plane must flip on every 64th rise
   task automatic divider_check;
      logic lvl;
      int n;
      n = 0;
      lvl = plane_out;
      while (plane_out === lvl && n < 200) begin
         pulse_tb();
         n++;
      end
      lvl = plane_out;
      for (int i = 1; i <= 64; i++) begin
         pulse_tb();
         check_bit(plane_out, (i == 64) ? ~lvl : lvl);
      end
   endtask

   task automatic final_report;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, watchdog and main sequence
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // A run of a few thousand cycles is expected; this margin is generous
   initial begin
      #80us;
      failures++;
      final_report();
   end

   initial begin
      failures = 0;
      compares = 0;
      reset = 1'b1;
      data = 4'h0;
      pick = 2'h0;
      cs1_n = 1'b1;
      cs2_n = 1'b1;
      timebase = 1'b1;
      run = 1'b0;
      for (int i = 0; i < 4; i++) begin
         exp_pat[i] = 7'h00;
      end
      idle(4);
      reset = 1'b0;
      idle(2);
      check_all(1'b0);
      check_bit(plane_oe, 1'b1);
      // Every value once, with the digit code cycling through all four codes
      for (int v = 0; v < 16; v++) begin
         bus_write(v[3:0], v[1:0], v[0]);
      end
      // One select low keeps the buffer shut, so its later rise stores the old word
      cs1_n = 1'b0;
      data = 4'h8;
      pick = 2'h3;
      idle(6);
      cs1_n = 1'b1;
      idle(12);
      check_all(plane_out);
      // Patterns hold with no bus traffic
      idle(2000);
      check_all(plane_out);
      // A low pulse shorter than the glitch limit keeps master mode
      timebase = 1'b0;
      for (int i = 0; i < 200; i++) begin
         idle(1);
         check_bit(plane_oe, 1'b1);
      end
      timebase = 1'b1;
      idle(20);
      // Held low: slave mode, segments follow the external plane
      timebase = 1'b0;
      idle(270);
      check_bit(plane_oe, 1'b0);
      run = 1'b1;
      for (int k = 0; k < 2; k++) begin
         wait_pin();
         idle(8);
         check_all(plane_pin);
      end
      timebase = 1'b1;
      idle(5);
      check_bit(plane_oe, 1'b1);
      run = 1'b0;
      idle(4);
      divider_check();
      final_report();
   end
endmodule
